// *** verilog/supply_reset_ctrl.sv ***
// Supply-drop reset, threshold select register and reset-source flags.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`include "supply_reset_consts.svh"
module supply_reset_ctrl #(
  parameter int QUALIFY_CYCLES = `SUPPLY_DROP_QUALIFY_CYC,
  parameter int SOFT_DELAY_CYCLES = `SOFT_RESET_DELAY_CYC,
  parameter int HOLD_CYCLES = `CORE_RESET_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic power_saving,
  input wire logic watchdog_timeout,
  input wire logic reset_ctrl_soft_reset,
  input wire logic watchdog_ctrl_soft_reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  output supply_reset_pkg::threshold_level_t selected_threshold_voltage,
  output logic core_reset,
  output logic pc_sp_clear,
  output logic power_on_init,
  output logic timeout_status_flag,
  output logic power_down_status_flag,
  output logic irq
);

  localparam int CW = 32;

  // Returns {valid, level} for a threshold pattern; used for the output and the validity check.
  function automatic logic [2:0] decode_threshold(input logic [7:0] pat);
    unique case (pat)
      `PAT_2V10: decode_threshold = {1'b1, supply_reset_pkg::LVL_2V10};
      `PAT_2V55: decode_threshold = {1'b1, supply_reset_pkg::LVL_2V55};
      `PAT_3V15: decode_threshold = {1'b1, supply_reset_pkg::LVL_3V15};
      `PAT_3V80: decode_threshold = {1'b1, supply_reset_pkg::LVL_3V80};
      default: decode_threshold = 3'h0;
    endcase
  endfunction

  logic [7:0] supply_threshold_select;
  logic [3:0] reset_source_flags;
  logic [2:0] events;
  logic [2:0] event_mask;
  logic [CW-1:0] drop_cnt;
  logic [CW-1:0] soft_cnt;
  logic [CW-1:0] hold_cnt;
  logic drop_done;
  logic running;
  logic drop_fire;
  logic bad_fire;
  logic wdt_run_fire;
  logic wdt_save_fire;
  logic pattern_valid;
  logic [2:0] decoded;
  supply_reset_pkg::core_state_t core_state;

  assign running = ~power_saving;
  assign decoded = decode_threshold(supply_threshold_select);
  assign pattern_valid = decoded[2];
  // A low held for QUALIFY_CYCLES cycles fires on the following one, so it must outlast the time.
  assign drop_fire = running & supply_low & ~drop_done & (drop_cnt == QUALIFY_CYCLES);
  assign bad_fire = ~pattern_valid & (soft_cnt == SOFT_DELAY_CYCLES);
  assign wdt_run_fire = watchdog_timeout & running;
  assign wdt_save_fire = watchdog_timeout & power_saving;

  // Supply-low qualification; the count clears in the saving modes so a low supply never resets a sleeping core.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drop_cnt <= '0;
      drop_done <= 1'b0;
    end else if (!supply_low || !running) begin
      drop_cnt <= '0;
      drop_done <= 1'b0;
    end else if (drop_fire) begin
      drop_done <= 1'b1; // One reset per drop; a new one needs the supply to recover or a saving mode first.
    end else if (drop_cnt < QUALIFY_CYCLES) begin
      drop_cnt <= drop_cnt + 1'b1;
    end
  end

  // Soft reset delay: an undefined pattern must persist this long; a valid rewrite aborts it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      soft_cnt <= '0;
    end else if (pattern_valid || bad_fire) begin
      soft_cnt <= '0;
    end else begin
      soft_cnt <= soft_cnt + 1'b1;
    end
  end

  // Threshold register; a qualified drop does not touch it, a bad-pattern reset restores it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      supply_threshold_select <= `THRESHOLD_POR;
    end else if (bad_fire) begin
      supply_threshold_select <= `THRESHOLD_POR;
    end else if (reg_wr && reg_addr == `ADDR_THRESHOLD) begin
      supply_threshold_select <= reg_wr_data;
    end
  end

  // The comparator keeps the last valid level while an undefined pattern waits out its delay.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selected_threshold_voltage <= supply_reset_pkg::LVL_2V10;
    end else if (pattern_valid) begin
      selected_threshold_voltage <= supply_reset_pkg::threshold_level_t'(decoded[1:0]);
    end
  end

  // Source flags: hardware sets, software clears by writing zero; a set in the same cycle wins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_source_flags <= `FLAGS_POR;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr && reg_addr == `ADDR_FLAGS && !reg_wr_data[i]) begin
          reset_source_flags[i] <= 1'b0;
        end
      end
      if (drop_fire) begin
        reset_source_flags[`FLAG_DROP] <= 1'b1;
      end
      if (bad_fire) begin
        reset_source_flags[`FLAG_THRESHOLD] <= 1'b1;
      end
      if (reset_ctrl_soft_reset) begin
        reset_source_flags[`FLAG_RST_CTRL] <= 1'b1;
      end
      if (watchdog_ctrl_soft_reset) begin
        reset_source_flags[`FLAG_WDT_CTRL] <= 1'b1;
      end
    end
  end

  // Time-out and power-down status; only power-on clears them.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timeout_status_flag <= 1'b0;
      power_down_status_flag <= 1'b0;
    end else if (wdt_save_fire) begin
      timeout_status_flag <= 1'b1;
      power_down_status_flag <= 1'b1;
    end else if (wdt_run_fire) begin
      timeout_status_flag <= 1'b1;
    end
  end

  // All full-reset requests merge into one held core reset; a request while held restarts the hold.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_state <= supply_reset_pkg::CORE_HOLD;
      hold_cnt <= '0;
    end else begin
      unique case (core_state)
        supply_reset_pkg::CORE_RUN: begin
          if (drop_fire || bad_fire || wdt_run_fire) begin
            core_state <= supply_reset_pkg::CORE_HOLD;
            hold_cnt <= '0;
          end
        end
        supply_reset_pkg::CORE_HOLD: begin
          if (drop_fire || bad_fire || wdt_run_fire) begin
            hold_cnt <= '0;
          end else if (hold_cnt == HOLD_CYCLES - 1) begin
            core_state <= supply_reset_pkg::CORE_RUN;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  assign core_reset = (core_state == supply_reset_pkg::CORE_HOLD);

  // Saving-mode time-out clears only PC and SP; power-on init marks the POR start state.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_sp_clear <= 1'b0;
      power_on_init <= 1'b1;
    end else begin
      pc_sp_clear <= wdt_save_fire;
      if (!core_reset) begin
        power_on_init <= 1'b0;
      end
    end
  end

  // Event status (write one to clear, set wins) and mask for the interrupt line.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      events <= 3'h0;
      event_mask <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_MASK) begin
        event_mask <= reg_wr_data[2:0];
      end
      events <= (events & ~((reg_wr && reg_addr == `ADDR_EVENTS) ? reg_wr_data[2:0] : 3'h0))
                | {watchdog_timeout, bad_fire, drop_fire};
    end
  end

  assign irq = |(events & event_mask);

  // Read data stands in the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_THRESHOLD: reg_rd_data <= supply_threshold_select;
        `ADDR_FLAGS: reg_rd_data <= {4'h0, reset_source_flags};
        `ADDR_STATUS: reg_rd_data <= {6'h00, power_down_status_flag, timeout_status_flag};
        `ADDR_EVENTS: reg_rd_data <= {5'h00, events};
        `ADDR_MASK: reg_rd_data <= {5'h00, event_mask};
        default: reg_rd_data <= 8'h00;
      endcase
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  // Checks kept beside the logic.
  sequence s_drop_qualified;
    running & supply_low & (drop_cnt == QUALIFY_CYCLES) & ~drop_done;
  endsequence
  sequence s_reset_taken;
    core_reset & reset_source_flags[`FLAG_DROP];
  endsequence

  property p_drop_reset;
    @(posedge ref_clk) disable iff (rst) s_drop_qualified |=> s_reset_taken;
  endproperty
  a_drop_reset: assert property (p_drop_reset) else $error("drop did not reset");

  property p_glitch_ignored;
    @(posedge ref_clk) disable iff (rst) !supply_low |=> (drop_cnt == 0) && !drop_fire;
  endproperty
  a_glitch_ignored: assert property (p_glitch_ignored) else $error("short low counted");

  property p_decode_valid;
    @(posedge ref_clk) disable iff (rst)
      (supply_threshold_select == `PAT_3V15) |=> selected_threshold_voltage == supply_reset_pkg::LVL_3V15;
  endproperty
  a_decode_valid: assert property (p_decode_valid) else $error("threshold decode wrong");

  property p_bad_restore;
    @(posedge ref_clk) disable iff (rst)
      bad_fire |=> supply_threshold_select == `THRESHOLD_POR && reset_source_flags[`FLAG_THRESHOLD] && core_reset;
  endproperty
  a_bad_restore: assert property (p_bad_restore) else $error("bad pattern not handled");

  property p_soft_delay;
    @(posedge ref_clk) disable iff (rst) bad_fire |-> soft_cnt == SOFT_DELAY_CYCLES && !pattern_valid;
  endproperty
  a_soft_delay: assert property (p_soft_delay) else $error("soft reset too early");

  property p_drop_keeps_threshold;
    @(posedge ref_clk) disable iff (rst)
      drop_fire && !bad_fire && !reg_wr |=> $stable(supply_threshold_select);
  endproperty
  a_drop_keeps_threshold: assert property (p_drop_keeps_threshold) else $error("threshold changed");

  property p_saving_inhibit;
    @(posedge ref_clk) disable iff (rst) power_saving |-> !drop_fire;
  endproperty
  a_saving_inhibit: assert property (p_saving_inhibit) else $error("drop reset while saving");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (rst)
      reset_source_flags[`FLAG_DROP] && !(reg_wr && reg_addr == `ADDR_FLAGS) |=> reset_source_flags[`FLAG_DROP];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("drop flag lost");

  property p_wdt_run;
    @(posedge ref_clk) disable iff (rst)
      wdt_run_fire && !wdt_save_fire |=> timeout_status_flag && core_reset && $stable(power_down_status_flag);
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("running time-out wrong");

  // A bad pattern may still fire while the core sleeps, so only that request may raise the core reset here.
  property p_wdt_save;
    @(posedge ref_clk) disable iff (rst)
      wdt_save_fire && !core_reset |=> pc_sp_clear && timeout_status_flag && power_down_status_flag
        && (!core_reset || $past(bad_fire));
  endproperty
  a_wdt_save: assert property (p_wdt_save) else $error("saving time-out wrong");

  // Run counters for the checks below, kept apart from the working counters so a slip in those shows.
  // Both saturate, so a supply that stays low for a long time cannot wrap them into a false pass.
  logic [CW-1:0] low_run;
  logic [CW-1:0] bad_run;

  // Consecutive sampled cycles of a low supply while the core runs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_run <= '0;
    end else if (!supply_low || power_saving) begin
      low_run <= '0;
    end else if (low_run != QUALIFY_CYCLES) begin
      low_run <= low_run + 1'b1;
    end
  end

  // Consecutive cycles in which the threshold register holds an undefined pattern.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bad_run <= '0;
    end else if (pattern_valid) begin
      bad_run <= '0;
    end else if (bad_run != SOFT_DELAY_CYCLES) begin
      bad_run <= bad_run + 1'b1;
    end
  end

  // A drop may only fire once the low supply has outlasted the qualify time and is still low.
  property p_drop_outlasts;
    @(posedge ref_clk) disable iff (rst) drop_fire |-> (low_run == QUALIFY_CYCLES) && supply_low;
  endproperty
  a_drop_outlasts: assert property (p_drop_outlasts) else $error("drop fired before qualify time");

  // The undefined-pattern reset comes neither early nor late.
  property p_soft_not_early;
    @(posedge ref_clk) disable iff (rst) bad_fire |-> bad_run == SOFT_DELAY_CYCLES;
  endproperty
  a_soft_not_early: assert property (p_soft_not_early) else $error("soft reset before delay");

  property p_soft_not_late;
    @(posedge ref_clk) disable iff (rst) !pattern_valid && (bad_run == SOFT_DELAY_CYCLES) |-> bad_fire;
  endproperty
  a_soft_not_late: assert property (p_soft_not_late) else $error("soft reset missing");

  // A supply-drop reset leaves both status flags as they were.
  property p_drop_keeps_status;
    @(posedge ref_clk) disable iff (rst)
      drop_fire && !watchdog_timeout |=> $stable(timeout_status_flag) && $stable(power_down_status_flag);
  endproperty
  a_drop_keeps_status: assert property (p_drop_keeps_status) else $error("drop changed status");

  // The time-out flag is sticky; nothing but a power-on reset lowers it.
  property p_status_sticky;
    @(posedge ref_clk) disable iff (rst) timeout_status_flag |=> timeout_status_flag;
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("time-out flag lost");

  // The unimplemented top of the flag register never reads as one.
  property p_flags_top_zero;
    @(posedge ref_clk) disable iff (rst) reg_rd && (reg_addr == `ADDR_FLAGS) |=> reg_rd_data[7:4] == 4'h0;
  endproperty
  a_flags_top_zero: assert property (p_flags_top_zero) else $error("flag top bits set");

  // Power-on marking ends one cycle after the core first leaves reset.
  property p_init_ends;
    @(posedge ref_clk) disable iff (rst) !core_reset |=> !power_on_init;
  endproperty
  a_init_ends: assert property (p_init_ends) else $error("power-on mark stuck");

  // Every full-reset request, in either state, starts the hold over from zero.
  sequence s_full_request;
    drop_fire || bad_fire || wdt_run_fire;
  endsequence
  sequence s_hold_restart;
    core_reset && (hold_cnt == 0);
  endsequence
  property p_merge_restart;
    @(posedge ref_clk) disable iff (rst) s_full_request |=> s_hold_restart;
  endproperty
  a_merge_restart: assert property (p_merge_restart) else $error("reset request lost");

  // The highest and the second threshold decode as well, not only the third one.
  property p_decode_top;
    @(posedge ref_clk) disable iff (rst)
      (supply_threshold_select == `PAT_3V80) |=> selected_threshold_voltage == supply_reset_pkg::LVL_3V80;
  endproperty
  a_decode_top: assert property (p_decode_top) else $error("top threshold decode wrong");

  property p_decode_low;
    @(posedge ref_clk) disable iff (rst)
      (supply_threshold_select == `PAT_2V55) |=> selected_threshold_voltage == supply_reset_pkg::LVL_2V55;
  endproperty
  a_decode_low: assert property (p_decode_low) else $error("second threshold decode wrong");

endmodule // supply_reset_ctrl

// *** verilog/supply_reset_consts.svh ***
// Constants for the supply-drop reset and reset-source flag logic.
`ifndef SUPPLY_RESET_CONSTS_SVH
`define SUPPLY_RESET_CONSTS_SVH
`define CLK_PERIOD_NS 25
`define SUPPLY_DROP_QUALIFY_NS 120000
`define SOFT_RESET_DELAY_NS 50000
`define CORE_RESET_HOLD_NS 400
`define SUPPLY_DROP_QUALIFY_CYC (`SUPPLY_DROP_QUALIFY_NS / `CLK_PERIOD_NS)
`define SOFT_RESET_DELAY_CYC ((`SOFT_RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_RESET_HOLD_CYC ((`CORE_RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_THRESHOLD 3'h0
`define ADDR_FLAGS 3'h1
`define ADDR_STATUS 3'h2
`define ADDR_EVENTS 3'h3
`define ADDR_MASK 3'h4
`define PAT_2V10 8'h55
`define PAT_2V55 8'h33
`define PAT_3V15 8'h99
`define PAT_3V80 8'hAA
`define THRESHOLD_POR 8'h55
`define FLAG_WDT_CTRL 0
`define FLAG_THRESHOLD 1
`define FLAG_DROP 2
`define FLAG_RST_CTRL 3
`define FLAGS_POR 4'h0
`define EV_DROP 0
`define EV_BAD_PATTERN 1
`define EV_WDT 2
`define STAT_TIMEOUT 0
`define STAT_POWER_DOWN 1
`endif

// *** verilog/supply_reset_pkg.sv ***
// Types shared by the supply-drop reset logic.
package supply_reset_pkg;
  typedef enum logic [1:0] {
    LVL_2V10 = 2'h0,
    LVL_2V55 = 2'h1,
    LVL_3V15 = 2'h2,
    LVL_3V80 = 2'h3
  } threshold_level_t;
  typedef enum logic [1:0] {
    CORE_RUN = 2'b01,
    CORE_HOLD = 2'b10
  } core_state_t;
endpackage

// *** sim/supply_drop_partner.sv ***
// Behavioural model of the supply comparator and the watchdog overflow.
`timescale 1ns/100ps
module supply_drop_partner (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] drop_len,
  input wire logic drop_go,
  input wire logic wdt_go,
  output logic supply_low,
  output logic watchdog_timeout
);
  logic [7:0] left;
  // The comparator stays low-supply for exactly the commanded cycles, then recovers so the detector rearms.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      left <= 8'h00;
    end else if (drop_go) begin
      left <= drop_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign supply_low = (left != 8'h00);
  // An overflow is a single-cycle pulse, as the real counter gives it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      watchdog_timeout <= 1'b0;
    end else begin
      watchdog_timeout <= wdt_go;
    end
  end
endmodule // supply_drop_partner

// *** sim/supply_reset_ctrl_tb_top.sv ***
// Self-checking bench for the supply-drop reset and reset-source flags.
`timescale 1ns/100ps
`include "supply_reset_consts.svh"
module supply_reset_ctrl_tb_top;
  localparam int QUAL = 4;
  localparam int SOFT = 6;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic power_saving = 1'b0;
  logic rc_soft = 1'b0;
  logic wc_soft = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] drop_len = 8'h00;
  logic drop_go = 1'b0;
  logic wdt_go = 1'b0;
  logic supply_low, watchdog_timeout, core_reset, pc_sp_clear, power_on_init, to_flag, pd_flag, irq;
  logic [7:0] reg_rd_data;
  supply_reset_pkg::threshold_level_t selected_threshold_voltage;
  logic [31:0] seed = 32'h0000649F;
  logic [7:0] p;
  int bad_count = 0;
  int samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  supply_reset_ctrl #(.QUALIFY_CYCLES(QUAL), .SOFT_DELAY_CYCLES(SOFT), .HOLD_CYCLES(3)) uut (.ref_clk(ref_clk),
    .rst(rst), .supply_low(supply_low), .power_saving(power_saving), .watchdog_timeout(watchdog_timeout),
    .reset_ctrl_soft_reset(rc_soft), .watchdog_ctrl_soft_reset(wc_soft), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .selected_threshold_voltage(selected_threshold_voltage), .core_reset(core_reset),
    .pc_sp_clear(pc_sp_clear), .power_on_init(power_on_init), .timeout_status_flag(to_flag),
    .power_down_status_flag(pd_flag), .irq(irq));
  supply_drop_partner model (.ref_clk(ref_clk), .rst(rst), .drop_len(drop_len), .drop_go(drop_go),
    .wdt_go(wdt_go), .supply_low(supply_low), .watchdog_timeout(watchdog_timeout));
  // Expected level code of a pattern; all ones marks a pattern that must end in a reset.
  function automatic logic [7:0] lvl_of(input logic [7:0] v);
    case (v)
      `PAT_2V10: return 8'h00;
      `PAT_2V55: return 8'h01;
      `PAT_3V15: return 8'h02;
      `PAT_3V80: return 8'h03;
      default: return 8'hFF;
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rd_data, exp);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      chk({7'h00, core_reset}, 8'h00);
    end
  endtask
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 40 && core_reset !== lvl; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h00, core_reset}, {7'h00, lvl});
    if (core_reset !== lvl) stop_test();
  endtask
  task automatic pulse(input logic [1:0] k, input logic [7:0] n);
    @(posedge ref_clk);
    drop_len <= n;
    drop_go <= k[0];
    wdt_go <= k[1];
    @(posedge ref_clk);
    drop_go <= 1'b0;
    wdt_go <= 1'b0;
  endtask
  task automatic cold();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wait_core(1'b0);
    chk({7'h00, power_on_init}, 8'h01);
    @(posedge ref_clk);
    #1;
    chk({7'h00, power_on_init}, 8'h00);
    rd(`ADDR_THRESHOLD, `THRESHOLD_POR);
    rd(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_STATUS, 8'h00);
  endtask
  // Four corner patterns first, then random ones, which are mostly undefined and must reset.
  initial begin
    cold();
    rd(3'h7, 8'h00);
    wr(3'h7, 8'hFF);
    for (int k = 0; k < 10; k++) begin
      seed = xs(seed);
      p = seed[7:0];
      if (k == 0) p = `PAT_2V10;
      if (k == 1) p = `PAT_2V55;
      if (k == 2) p = `PAT_3V15;
      if (k == 3) p = `PAT_3V80;
      wr(`ADDR_THRESHOLD, p);
      if (lvl_of(p) !== 8'hFF) begin
        rd(`ADDR_THRESHOLD, p);
        chk({6'h00, selected_threshold_voltage}, lvl_of(p));
      end else begin
        quiet(SOFT);
        wait_core(1'b1);
        wait_core(1'b0);
        rd(`ADDR_THRESHOLD, `THRESHOLD_POR);
        rd(`ADDR_FLAGS, 8'h02);
        wr(`ADDR_FLAGS, 8'h00);
      end
    end
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_MASK, 8'h07);
    wr(`ADDR_EVENTS, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_THRESHOLD, `PAT_3V15);
    pulse(2'b01, 8'(QUAL));
    quiet(12);
    pulse(2'b01, 8'(QUAL + 1));
    wait_core(1'b1);
    chk({7'h00, irq}, 8'h01);
    wait_core(1'b0);
    wr(`ADDR_FLAGS, 8'hF4);
    rd(`ADDR_FLAGS, 8'h04);
    wr(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_FLAGS, 8'h00);
    rd(`ADDR_THRESHOLD, `PAT_3V15);
    rd(`ADDR_STATUS, 8'h00);
    wr(`ADDR_EVENTS, 8'h07);
    chk({7'h00, irq}, 8'h00);
    pulse(2'b10, 8'h00);
    wait_core(1'b1);
    chk({6'h00, pd_flag, to_flag}, 8'h01);
    wait_core(1'b0);
    rd(`ADDR_EVENTS, 8'h04);
    wr(`ADDR_EVENTS, 8'h04);
    power_saving <= 1'b1;
    pulse(2'b01, 8'(QUAL + 3));
    quiet(12);
    pulse(2'b10, 8'h00);
    @(posedge ref_clk);
    #1;
    chk({7'h00, pc_sp_clear}, 8'h01);
    quiet(6);
    rd(`ADDR_THRESHOLD, `PAT_3V15);
    rd(`ADDR_STATUS, 8'h03);
    power_saving <= 1'b0;
    rc_soft <= 1'b1;
    wc_soft <= 1'b1;
    @(posedge ref_clk);
    rc_soft <= 1'b0;
    wc_soft <= 1'b0;
    wait_core(1'b0);
    rd(`ADDR_FLAGS, 8'h09);
    cold();
    stop_test();
  end
endmodule // supply_reset_ctrl_tb_top
